// File: design/dcs_top.v
// serial line-coding block: gap-free serialiser, comma-aligned deserialiser,
// running disparity and code checking
// assumes tx_bit_clk, rx_bit_clk and rx_serial are asynchronous pins, each
// bit clock well below a quarter of clk; link_init comes from logic on clk
`timescale 1ns/100ps
`include "dcs_defs.vh"

module dcs_top (
  clk,
  sys_rst,
  tx_bit_clk,
  tx_char,
  tx_char_valid,
  tx_char_ready,
  tx_serial,
  tx_idle_sent,
  rx_bit_clk,
  rx_serial,
  link_init,
  init_rd_pos,
  rx_char,
  rx_char_valid,
  rx_comma,
  rx_aligned,
  rx_code_err,
  rx_disp_err,
  rx_rd_pos,
  link_fault,
  rx_err_count
);
  input  wire                     clk;
  input  wire                     sys_rst;
  input  wire                     tx_bit_clk;
  input  wire [`DCS_CHAR_W-1:0]   tx_char;
  input  wire                     tx_char_valid;
  output wire                     tx_char_ready;
  output reg                      tx_serial;
  output reg                      tx_idle_sent;
  input  wire                     rx_bit_clk;
  input  wire                     rx_serial;
  input  wire                     link_init;
  input  wire                     init_rd_pos;
  output reg  [`DCS_CHAR_W-1:0]   rx_char;
  output reg                      rx_char_valid;
  output reg                      rx_comma;
  output reg                      rx_aligned;
  output reg                      rx_code_err;
  output reg                      rx_disp_err;
  output reg                      rx_rd_pos;
  output reg                      link_fault;
  output reg  [`DCS_ERRCNT_W-1:0] rx_err_count;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [2:0] txc_sync_q;
  reg [2:0] rxc_sync_q;
  reg [1:0] rxd_sync_q;
  wire      tx_edge;
  wire      rx_edge;
  wire      rx_bit;

  always @(posedge clk) begin
    if (sys_rst) begin
      txc_sync_q <= 3'h0;
      rxc_sync_q <= 3'h0;
      rxd_sync_q <= 2'h0;
    end else begin
      txc_sync_q <= {txc_sync_q[1:0], tx_bit_clk};
      rxc_sync_q <= {rxc_sync_q[1:0], rx_bit_clk};
      rxd_sync_q <= {rxd_sync_q[0], rx_serial};
    end
  end

  // edges are taken from the second and third stages only
  assign tx_edge = txc_sync_q[1] & ~txc_sync_q[2];
  assign rx_edge = rxc_sync_q[1] & ~rxc_sync_q[2];
  assign rx_bit  = rxd_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // transmit serialiser
  reg [`DCS_CHAR_W-1:0] tx_sr_q;
  reg [`DCS_CNT_W-1:0]  tx_cnt_q;
  wire                  tx_load;
  wire [`DCS_CHAR_W-1:0] tx_next;

  // load exactly when the tenth bit has gone out
  assign tx_load       = tx_edge && (tx_cnt_q == `DCS_LAST_BIT);   // [R11]
  assign tx_char_ready = tx_load;
  // an idle comma fills the slot when no character is offered
  assign tx_next       = tx_char_valid ? tx_char : `DCS_IDLE_CHAR; // [R11]

  always @(posedge clk) begin
    if (sys_rst) begin
      tx_sr_q      <= {`DCS_CHAR_W{1'b0}};
      tx_cnt_q     <= `DCS_LAST_BIT;
      tx_serial    <= 1'b0;
      tx_idle_sent <= 1'b0;
    end else begin
      tx_idle_sent <= tx_load & ~tx_char_valid;
      if (tx_load) begin
        tx_serial <= tx_next[`DCS_CHAR_W-1];                        // [R10]
        tx_sr_q   <= {tx_next[`DCS_CHAR_W-2:0], 1'b0};              // [R10]
        tx_cnt_q  <= `DCS_FIRST_BIT;
      end else if (tx_edge) begin
        tx_serial <= tx_sr_q[`DCS_CHAR_W-1];                        // [R10]
        tx_sr_q   <= {tx_sr_q[`DCS_CHAR_W-2:0], 1'b0};              // [R10]
        tx_cnt_q  <= tx_cnt_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive deserialiser and character alignment
  reg  [`DCS_CHAR_W-1:0] rx_sr_q;
  reg  [`DCS_CNT_W-1:0]  rx_cnt_q;
  wire [`DCS_CHAR_W-1:0] rx_sr_d;
  wire                   comma_hit;
  wire                   rx_full;
  wire                   rx_take;

  assign rx_sr_d   = {rx_sr_q[`DCS_CHAR_W-2:0], rx_bit};            // [R12]
  // comma sits in the first seven bits in, so three more bits have
  // followed it and the next bit starts a new character
  assign comma_hit = (rx_sr_d[9:3] == `DCS_COMMA_POS) ||
                     (rx_sr_d[9:3] == `DCS_COMMA_NEG);              // [R14] [R15]
  assign rx_full   = (rx_cnt_q == `DCS_LAST_BIT);
  assign rx_take   = rx_edge && (comma_hit || (rx_aligned && rx_full)); // [R13]

  always @(posedge clk) begin
    if (sys_rst) begin
      rx_sr_q    <= {`DCS_CHAR_W{1'b0}};
      rx_cnt_q   <= `DCS_FIRST_BIT;
      rx_aligned <= 1'b0;
    end else if (rx_edge) begin
      rx_sr_q <= rx_sr_d;                                           // [R12]
      if (comma_hit || rx_full) begin
        rx_cnt_q <= `DCS_FIRST_BIT;                                 // [R15]
      end else begin
        rx_cnt_q <= rx_cnt_q + 4'h1;
      end
      if (comma_hit) begin
        rx_aligned <= 1'b1;                                         // [R15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // disparity tracking and error reporting
  reg  track_q;
  wire chk_rd;
  wire chk_code_err;
  wire chk_disp_err;
  wire check_now;
  wire err_now;

  dcs_disp_chk u_chk (
    .sym      (rx_sr_d),
    .rd_in    (rx_rd_pos),
    .rd_out   (chk_rd),
    .code_err (chk_code_err),
    .disp_err (chk_disp_err)
  );

  assign check_now = rx_take && track_q;                            // [R5]
  assign err_now   = check_now && (chk_code_err || chk_disp_err);   // [R9]

  // parallel hand-over of each aligned character
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_char       <= {`DCS_CHAR_W{1'b0}};
      rx_char_valid <= 1'b0;
      rx_comma      <= 1'b0;
    end else begin
      rx_char_valid <= rx_take;                                     // [R13]
      rx_comma      <= rx_take & comma_hit;
      if (rx_take) begin
        rx_char <= rx_sr_d;                                         // [R13]
      end
    end
  end

  // running disparity, restarted by each link initialisation
  always @(posedge clk) begin
    if (sys_rst) begin
      track_q   <= 1'b0;
      rx_rd_pos <= `DCS_RD_NEG;                                     // [R16]
    end else if (link_init) begin
      track_q   <= 1'b1;                                            // [R5]
      rx_rd_pos <= init_rd_pos;                                     // [R16] [R1]
    end else if (check_now) begin
      rx_rd_pos <= chk_rd;                                          // [R7] [R1]
    end
  end

  // error pulses, sticky fault and saturating count
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_code_err  <= 1'b0;
      rx_disp_err  <= 1'b0;
      link_fault   <= 1'b0;
      rx_err_count <= {`DCS_ERRCNT_W{1'b0}};
    end else begin
      rx_code_err <= check_now & chk_code_err;                      // [R8]
      rx_disp_err <= check_now & chk_disp_err;                      // [R3]
      // a new error wins over the clear from link_init
      if (err_now) begin
        link_fault <= 1'b1;                                         // [R4] [R9]
      end else if (link_init) begin
        link_fault <= 1'b0;                                         // [R16]
      end
      if (err_now) begin
        if (rx_err_count != `DCS_ERRCNT_MAX) begin
          rx_err_count <= rx_err_count + 8'h01;                     // [R9]
        end
      end else if (link_init) begin
        rx_err_count <= {`DCS_ERRCNT_W{1'b0}};                      // [R16]
      end
    end
  end

endmodule // dcs_top

// File: design/dcs_defs.vh
// constants for the disparity-checking serialiser/deserialiser
// assumes inclusion by dcs_top.v and dcs_disp_chk.v only
// How it works
// R1 - running disparity is only ever plus one or minus one, either start allowed
// R2 - ten-bit symbol ones minus zeros must be plus two, zero or minus two
// R3 - running disparity plus symbol disparity of plus or minus three is an error
// R4 - a disparity error raises a link fault so the link is initialised again
// R5 - disparity tracking starts at link initialisation and covers every later symbol
// R6 - six-bit and four-bit sub-codes are each checked for plus two, zero, minus two
// R7 - running disparity is updated and checked after each sub-code
// R8 - an illegal sub-code pattern is flagged in the same character slot
// R9 - both invalid characters and disparity errors are watched and reported
// R10 - transmit character is loaded in parallel and shifted out one bit per bit clock
// R11 - next character loads right after the tenth bit, leaving no gap
// R12 - receive bits are shifted in on the recovered receive bit clock
// R13 - parallel output only for a complete aligned character, once per ten bits
// R14 - character boundary found by searching for either seven-bit comma
// R15 - fourth bit after comma end starts the next character; counter aligns there
// R16 - link initialisation reloads configured disparity and clears error indications; a same-cycle error sets link_fault and adds to the old rx_err_count
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

`define DCS_CHAR_W     10
`define DCS_CNT_W      4
`define DCS_LAST_BIT   4'h9
`define DCS_FIRST_BIT  4'h0
`define DCS_COMMA_POS  7'h1f
`define DCS_COMMA_NEG  7'h60
`define DCS_IDLE_CHAR  10'h0fa
`define DCS_RD_NEG     1'b0
`define DCS_RD_POS     1'b1
`define DCS_ERRCNT_W   8
`define DCS_ERRCNT_MAX 8'hff

`endif

// File: design/dcs_disp_chk.v
// sub-code and running disparity checker for one ten-bit symbol
// assumes symbol bit 9 is a (first on the wire) and bits 3:0 are fghj
`timescale 1ns/100ps
`include "dcs_defs.vh"

module dcs_disp_chk (
  sym,
  rd_in,
  rd_out,
  code_err,
  disp_err
);
  input  wire [`DCS_CHAR_W-1:0] sym;
  input  wire                   rd_in;
  output reg                    rd_out;
  output wire                   code_err;
  output wire                   disp_err;

  wire [2:0] ones6;
  wire [2:0] ones4;
  wire [3:0] ones10;
  wire       p6;
  wire       n6;
  wire       bad6;
  wire       p4;
  wire       n4;
  wire       bad4;
  wire       bad10;
  reg        rd_mid;

  assign ones6 = {2'h0, sym[9]} + {2'h0, sym[8]} + {2'h0, sym[7]}
               + {2'h0, sym[6]} + {2'h0, sym[5]} + {2'h0, sym[4]};
  assign ones4 = {2'h0, sym[3]} + {2'h0, sym[2]} + {2'h0, sym[1]} + {2'h0, sym[0]};
  assign ones10 = {1'b0, ones6} + {1'b0, ones4};

  // sub-code disparity classes
  assign p6   = (ones6 == 3'h4);                       // [R6]
  assign n6   = (ones6 == 3'h2);                       // [R6]
  assign bad6 = (ones6 < 3'h2) || (ones6 > 3'h4);      // [R6]
  assign p4   = (ones4 == 3'h3);                       // [R6]
  assign n4   = (ones4 == 3'h1);                       // [R6]
  assign bad4 = (ones4 == 3'h0) || (ones4 == 3'h4);    // [R6]
  assign bad10 = (ones10 < 4'h4) || (ones10 > 4'h6);   // [R2]

  assign code_err = bad6 | bad4 | bad10;               // [R8] [R9]

  // after each sub-code the state is clamped back to plus or minus one
  always @* begin
    rd_mid = rd_in;
    if (p6 || (bad6 && ones6 > 3'h3)) begin
      rd_mid = `DCS_RD_POS;                            // [R7] [R1]
    end else if (n6 || bad6) begin
      rd_mid = `DCS_RD_NEG;                            // [R7] [R1]
    end
    rd_out = rd_mid;
    if (p4 || (bad4 && ones4 > 3'h2)) begin
      rd_out = `DCS_RD_POS;                            // [R7] [R1]
    end else if (n4 || bad4) begin
      rd_out = `DCS_RD_NEG;                            // [R7] [R1]
    end
  end

  // plus one plus two, or minus one minus two, at either checkpoint
  assign disp_err = (rd_in & p6) | (~rd_in & n6)
                  | (rd_mid & p4) | (~rd_mid & n4);    // [R3] [R7]

endmodule // dcs_disp_chk

// File: testbench/dcs_top_sva.sv
// port checker for dcs_top: tx load timing, rx flags, link init handling
// assumes one clk domain and the bind below
`timescale 1ns/100ps
module dcs_top_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire [9:0] tx_char,
  input wire       tx_char_valid,
  input wire       tx_char_ready,
  input wire       tx_serial,
  input wire       tx_idle_sent,
  input wire       link_init,
  input wire       init_rd_pos,
  input wire       rx_char_valid,
  input wire       rx_comma,
  input wire       rx_aligned,
  input wire       rx_code_err,
  input wire       rx_disp_err,
  input wire       rx_rd_pos,
  input wire       link_fault,
  input wire [7:0] rx_err_count
);
  reg seen_q;
  always @(posedge clk) begin
    if (sys_rst)
      seen_q <= 1'b0;
    else if (link_init)
      seen_q <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence load_s; tx_char_ready; endsequence
  sequence err_s; rx_code_err || rx_disp_err; endsequence
  load_bit_a: assert property (load_s |=> tx_serial == ($past(tx_char_valid) ?
    $past(tx_char[9]) : 1'b0)) else $error("first bit wrong");
  ready_gap_a: assert property (load_s |=> (!tx_char_ready)[*8] ##[60:75] tx_char_ready)
    else $error("load spacing wrong");
  idle_flag_a: assert property (tx_char_ready && !tx_char_valid |-> ##[1:2] tx_idle_sent)
    else $error("idle flag missing");
  err_valid_a: assert property (err_s |-> rx_char_valid) else $error("error off slot");
  fault_set_a: assert property (err_s |-> ##[0:1] link_fault) else $error("no fault");
  track_gate_a: assert property (err_s |-> seen_q) else $error("error before init");
  init_rd_a: assert property (link_init |=> rx_rd_pos == $past(init_rd_pos))
    else $error("rd not reloaded");
  init_clear_a: assert property (link_init ##1 !(rx_code_err || rx_disp_err) |->
    rx_err_count == 8'h00 && !link_fault) else $error("not cleared");
  comma_flag_a: assert property (rx_comma |-> rx_char_valid && rx_aligned)
    else $error("comma flag wrong");
  aligned_hold_a: assert property (rx_aligned |=> rx_aligned) else $error("lost align");
endmodule // dcs_top_chk
bind dcs_top dcs_top_chk u_dcs_top_chk (.clk(clk), .sys_rst(sys_rst), .tx_char(tx_char),
  .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_serial(tx_serial),
  .tx_idle_sent(tx_idle_sent), .link_init(link_init), .init_rd_pos(init_rd_pos),
  .rx_char_valid(rx_char_valid), .rx_comma(rx_comma), .rx_aligned(rx_aligned),
  .rx_code_err(rx_code_err), .rx_disp_err(rx_disp_err), .rx_rd_pos(rx_rd_pos),
  .link_fault(link_fault), .rx_err_count(rx_err_count));

// File: testbench/dcs_peer.sv
// far end: free tx bit clock, rx bit clock only while sending a character
// assumes one caller of send at a time
`timescale 1ns/100ps
module dcs_peer (
  output reg tx_bit_clk,
  output reg rx_bit_clk,
  output reg rx_serial
);
  initial begin
    tx_bit_clk = 1'b0;
    rx_bit_clk = 1'b0;
    rx_serial = 1'b0;
    #3;
    forever #32 tx_bit_clk = ~tx_bit_clk;
  end
  // data set half a period before the rise, first bit is bit 9
  task send(input [9:0] ch);
    integer i;
    // one clk of spacing keeps the line change apart from the last one
    #8;
    for (i = 9; i >= 0; i = i - 1) begin
      rx_serial = ch[i];
      #32 rx_bit_clk = 1'b1;
      #32 rx_bit_clk = 1'b0;
    end
    rx_serial = ~ch[0];
  endtask
endmodule // dcs_peer

// File: testbench/dcs_top_tb.sv
// self-checking bench for dcs_top: random tx stream, rx sequences through dcs_peer
// assumes dcs_peer drives both bit clocks and rx_serial
`timescale 1ns/100ps
module dcs_top_tb;
  reg        clk, sys_rst, tx_char_valid, link_init, init_rd_pos;
  reg  [9:0] tx_char, got;
  reg [13:0] e;
  reg [10:0] txq[$];
  reg        idl;
  reg [13:0] rxq[$];
  integer    err_total, checks, cyc, seed, j;
  wire       tx_bit_clk, rx_bit_clk, rx_serial, tx_char_ready, tx_serial, tx_idle_sent;
  wire       rx_char_valid, rx_comma, rx_aligned, rx_code_err, rx_disp_err, rx_rd_pos;
  wire       link_fault;
  wire [9:0] rx_char;
  wire [7:0] rx_err_count;
  dcs_peer u_dcs_peer (.tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .rx_serial(rx_serial));
  dcs_top u_dcs_top (.clk(clk), .sys_rst(sys_rst), .tx_bit_clk(tx_bit_clk), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_serial(tx_serial),
    .tx_idle_sent(tx_idle_sent), .rx_bit_clk(rx_bit_clk), .rx_serial(rx_serial),
    .link_init(link_init), .init_rd_pos(init_rd_pos), .rx_char(rx_char),
    .rx_char_valid(rx_char_valid), .rx_comma(rx_comma), .rx_aligned(rx_aligned),
    .rx_code_err(rx_code_err), .rx_disp_err(rx_disp_err), .rx_rd_pos(rx_rd_pos),
    .link_fault(link_fault), .rx_err_count(rx_err_count));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task chk(input [13:0] g, input [13:0] x);
    checks = checks + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // received character with its flags
  task chk_rx(input [13:0] g, input [13:0] x);
    chk(g, x);
  endtask
  // sent character with its idle flag
  task chk_tx(input [10:0] g, input [10:0] x);
    chk({3'h0, g}, {3'h0, x});
  endtask
  task complete_run;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expectation {dcare, char, comma, code_err, disp_err}, then the peer sends it
  task put(input [9:0] ch, input cm, input ce, input de, input dc);
    rxq.push_back({dc, ch, cm, ce, de & dc});
    u_dcs_peer.send(ch);
  endtask
  task init_link(input pos);
    @(negedge clk);
    init_rd_pos = pos;
    link_init = 1'b1;
    @(negedge clk);
    link_init = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    tx_char <= 10'($urandom);
    tx_char_valid <= ($urandom % 4) != 0;
  end
  always @(posedge clk) begin
    if (tx_char_ready === 1'b1 && !sys_rst)
      txq.push_back({~tx_char_valid, (tx_char_valid ? tx_char : 10'h0fa)});
    if (rx_char_valid === 1'b1) begin
      e = (rxq.size() > 0) ? rxq.pop_front() : 14'h3fff;
      chk_rx({e[13], rx_char, rx_comma, rx_code_err, rx_disp_err & e[13]}, e);
    end
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run;
    end
  end
  initial begin
    forever begin
      @(posedge clk iff tx_char_ready === 1'b1);
      @(posedge clk) idl = tx_idle_sent;
      for (j = 9; j >= 0; j = j - 1) begin
        @(posedge tx_bit_clk);
        got[j] = tx_serial;
      end
      chk_tx({idl, got}, txq.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(50293);
    {sys_rst, link_init, init_rd_pos} = 3'h4;
    {err_total, checks, cyc} = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    init_link(1'b0);
    put(10'h0fa, 1'b1, 1'b0, 1'b0, 1'b1);
    put(10'h259, 1'b0, 1'b0, 1'b0, 1'b1);
    put(10'h289, 1'b0, 1'b0, 1'b0, 1'b1);
    put(10'h289, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (2) @(negedge clk);
    chk({4'h0, rx_aligned, link_fault, rx_err_count}, 14'h0301);
    $display("test 1 done: disparity error");
    init_link(1'b1);
    chk({4'h0, link_fault, rx_err_count, rx_rd_pos}, 14'h0001);
    put(10'h289, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk({13'h0000, rx_rd_pos}, 14'h0000);
    put(10'h270, 1'b0, 1'b1, 1'b0, 1'b0);
    put(10'h2f1, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk({4'h0, rx_aligned, link_fault, rx_err_count}, 14'h0302);
    $display("test 2 done: coding error");
    repeat (200) @(negedge clk);
    $display("test 3 done: tx stream");
    complete_run;
  end
endmodule // dcs_top_tb
